// [rtl/abz_pkg.sv]
package abz_pkg;

    // Clocking and ABZ update rate
    localparam int CLK_HZ = 10_000_000;
    localparam int UPDATE_HZ = 16_000_000;
    // Update period in core clocks, rounded down, never below one
    localparam int UPD_CYC = (CLK_HZ / UPDATE_HZ < 1) ? 1 : CLK_HZ / UPDATE_HZ;
    localparam int DIV_W = $clog2(UPD_CYC + 1);

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] REG_PPT_LO = 8'h04;
    localparam logic [7:0] REG_PPT_HI = 8'h05;
    localparam logic [7:0] REG_EDGE_POS = 8'h20;
    localparam logic [7:0] REG_ANGLE = 8'h21;

    // Field layout
    localparam int PPT_LO_LSB = 6;
    localparam int PPT_LO_MSB = 7;
    localparam int PPT_HI_LSB = 0;
    localparam int PPT_HI_MSB = 7;
    localparam int SHAPE_LSB = 8;
    localparam int SHAPE_MSB = 11;

    // Widths and reset values
    localparam int ANGLE_W = 14;
    localparam int PPT_W = 10;
    localparam int SHAPE_W = 4;
    localparam int EDGE_W = 12;
    localparam int EDGES_W = 13;
    localparam int FINE_W = 28;
    localparam logic [PPT_W-1:0] PPT_RESET = 10'h3FF;
    localparam logic [SHAPE_W-1:0] SHAPE_RESET = 4'h0;

    // Half an edge cell in fine units, and hysteresis in angle LSBs
    localparam logic [FINE_W-1:0] HALF_CELL = 28'h0002000;
    localparam int HYS_LSB = 2;

    // PWM padding: one pad of 1/514 period each side of the angle span
    localparam int PWM_PAD = 32;

endpackage

// [rtl/abz_pwm_gen.sv]
`timescale 1ns/1ps
module abz_pwm_gen #(
    parameter int ANGLE_W = 14,
    parameter int PAD = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Angle in and PWM out
    input wire logic [ANGLE_W-1:0] angle,
    output logic pwm_out
);

    localparam int PER = (1 << ANGLE_W) + 2 * PAD;
    localparam int CNT_W = $clog2(PER);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PER - 1);
    localparam logic [CNT_W-1:0] PAD_C = CNT_W'(PAD);
    localparam logic [CNT_W-1:0] DUTY_RESET = CNT_W'(PAD);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] duty;
        logic out;
    } abz_pwm_s;

    abz_pwm_s st_q;
    abz_pwm_s st_d;

    always_comb begin
        st_d = st_q;
        if (st_q.cnt == LAST) begin
            st_d.cnt = '0;
            // Angle is latched once per period so the duty never tears mid-period
            st_d.duty = CNT_W'(angle) + PAD_C; // [RULE10] [RULE11]
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        st_d.out = st_d.cnt < st_d.duty;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{cnt: LAST, duty: DUTY_RESET, out: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pwm_out = st_q.out;

    // High-time counter for checking only
    logic [CNT_W-1:0] hi_len_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hi_len_q <= '0;
        end else if (st_q.out) begin
            hi_len_q <= hi_len_q + 1'b1;
        end else begin
            hi_len_q <= '0;
        end
    end

    property p_pwm_min;
        @(posedge core_clk) disable iff (rst)
        $fell(st_q.out) |-> hi_len_q >= PAD_C;
    endproperty
    a_pwm_min: assert property (p_pwm_min) else $error("PWM high time below minimum"); // [RULE10]

    property p_pwm_max;
        @(posedge core_clk) disable iff (rst)
        $fell(st_q.out) |-> hi_len_q <= LAST - PAD_C;
    endproperty
    a_pwm_max: assert property (p_pwm_max) else $error("PWM high time above maximum"); // [RULE10]

    property p_pwm_res;
        @(posedge core_clk) disable iff (rst)
        $fell(st_q.out) |-> hi_len_q == st_q.duty;
    endproperty
    a_pwm_res: assert property (p_pwm_res) else $error("PWM high time does not match angle"); // [RULE11]

endmodule // abz_pwm_gen

// [rtl/abz_encoder_top.sv]
// Overview of operation
// RULE1 - Pulses per turn equal setting plus one
// RULE2 - Setting split: low bits 7:6, next register
// RULE3 - Index asserted once per turn at zero
// RULE4 - Index shape from 4-bit field, offset five
// RULE5 - Default shape: index rises with B falling
// RULE6 - Default index lasts half an A pulse
// RULE7 - Hysteresis suppresses noise-driven quadrature toggling
// RULE8 - Quadrature state recomputed at fixed update rate
// RULE9 - Edges never closer than one update period
// RULE10 - PWM duty bounded 1/514 to 513/514
// RULE11 - PWM duty resolves angle in 14 bits
// RULE12 - Receiver measures high and low time
// RULE13 - B shifted a quarter period from A
// RULE14 - Pulse setting resets to 1023
// RULE15 - Gray sequence, one channel changes per update; a resync after a lowered setting can change A and B together
`timescale 1ns/1ps
module abz_encoder_top #(
    parameter int HYS_LSB = abz_pkg::HYS_LSB
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Absolute angle from the sensing core, same clock
    input wire logic [abz_pkg::ANGLE_W-1:0] angle_in,
    // Register port
    input wire logic [abz_pkg::ADDR_W-1:0] addr,
    input wire logic [abz_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [abz_pkg::DATA_W-1:0] rdata,
    // Encoder and PWM outputs
    output logic quad_a,
    output logic quad_b,
    output logic quad_index,
    output logic pwm_out
);

    localparam int EW = abz_pkg::EDGE_W;
    localparam int FW = abz_pkg::FINE_W;
    localparam int NW = abz_pkg::EDGES_W;
    localparam int AW = abz_pkg::ANGLE_W;
    localparam logic [abz_pkg::DIV_W-1:0] DIV_LAST = abz_pkg::DIV_W'(abz_pkg::UPD_CYC - 1);
    localparam logic [FW-1:0] HYS_C = FW'(HYS_LSB);

    typedef struct packed {
        logic [abz_pkg::PPT_W-1:0] pulses_per_turn_setting;
        logic [abz_pkg::SHAPE_W-1:0] shape;
        logic [EW-1:0] cnt;
        logic [abz_pkg::DIV_W-1:0] div;
        logic qa;
        logic qb;
        logic qz;
        logic [abz_pkg::DATA_W-1:0] rdata;
    } abz_state_s;

    abz_state_s st_q;
    abz_state_s st_d;

    // Position arithmetic; scaled, total, cur, diff and thr in fine units of 1/2^14 edge cell
    logic [NW-1:0] edges;
    logic [FW-1:0] scaled;
    logic [FW-1:0] total;
    logic [FW-1:0] cur;
    logic signed [FW-1:0] diff;
    logic signed [FW-1:0] thr;
    logic [EW-1:0] target;
    logic tick;
    logic step_up;
    logic step_dn;
    logic resync;
    logic [EW-1:0] z_start;
    logic [EW-1:0] z_len;

    always_comb begin
        // Four edges per pulse, pulses = setting + 1
        edges = NW'({3'h0, st_q.pulses_per_turn_setting} + 13'h0001) << 2; // [RULE1]
        scaled = FW'(angle_in) * FW'(edges);
        total = FW'(edges) << AW;
        cur = (FW'(st_q.cnt) << AW) + abz_pkg::HALF_CELL;
        target = EW'(scaled >> AW);
        diff = $signed(scaled) - $signed(cur);
        // Take the short way round the circle
        if (diff >= $signed(total >> 1)) begin
            diff = diff - $signed(total);
        end else if (diff < -$signed(total >> 1)) begin
            diff = diff + $signed(total);
        end
        // Leave the current cell only past its edge plus a noise band
        thr = $signed(abz_pkg::HALF_CELL + HYS_C * FW'(edges)); // [RULE7]
        step_up = diff >= thr;
        step_dn = diff <= -thr;
        // A lowered setting can leave the count outside the new range
        resync = {1'b0, st_q.cnt} >= edges;
        tick = st_q.div == DIV_LAST; // [RULE8]
    end

    always_comb begin
        // Index start cell and length in edge cells
        z_start = EW'(st_q.shape[1:0]); // [RULE4]
        case (st_q.shape[3:2])
            2'b00: z_len = 12'h002; // [RULE6]
            2'b01: z_len = 12'h001;
            2'b10: z_len = 12'h003;
            2'b11: z_len = 12'h004;
            default: z_len = 12'h002;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.div = tick ? '0 : st_q.div + 1'b1;

        // Register writes
        if (wr_en) begin
            case (addr)
                abz_pkg::REG_PPT_LO: begin
                    st_d.pulses_per_turn_setting[1:0] = wdata[abz_pkg::PPT_LO_MSB:abz_pkg::PPT_LO_LSB]; // [RULE2]
                end
                abz_pkg::REG_PPT_HI: begin
                    st_d.pulses_per_turn_setting[9:2] = wdata[abz_pkg::PPT_HI_MSB:abz_pkg::PPT_HI_LSB]; // [RULE2]
                    st_d.shape = wdata[abz_pkg::SHAPE_MSB:abz_pkg::SHAPE_LSB]; // [RULE4]
                end
                default: begin
                end
            endcase
        end

        // Register reads answer in the next cycle only
        st_d.rdata = '0;
        if (rd_en) begin
            case (addr)
                abz_pkg::REG_PPT_LO: st_d.rdata = 16'(st_q.pulses_per_turn_setting[1:0]) << abz_pkg::PPT_LO_LSB;
                abz_pkg::REG_PPT_HI: st_d.rdata = {4'h0, st_q.shape, st_q.pulses_per_turn_setting[9:2]};
                abz_pkg::REG_EDGE_POS: st_d.rdata = 16'(st_q.cnt);
                abz_pkg::REG_ANGLE: st_d.rdata = 16'(angle_in);
                default: st_d.rdata = '0;
            endcase
        end

        // One edge step per update at most except on a resync, so one channel moves per update
        if (resync) begin
            st_d.cnt = target;
        end else if (tick && step_up) begin
            st_d.cnt = ({1'b0, st_q.cnt} == edges - 1'b1) ? '0 : st_q.cnt + 1'b1; // [RULE15] [RULE9]
        end else if (tick && step_dn) begin
            st_d.cnt = (st_q.cnt == '0) ? EW'(edges - 1'b1) : st_q.cnt - 1'b1; // [RULE15] [RULE9]
        end

        // Gray code: A = c0^c1, B = c1, so B trails A by a quarter pulse
        st_d.qa = st_d.cnt[0] ^ st_d.cnt[1]; // [RULE13]
        st_d.qb = st_d.cnt[1]; // [RULE13]
        // Cells near zero occur once per turn; default window opens as B falls
        st_d.qz = (st_d.cnt >= z_start) && (st_d.cnt < z_start + z_len); // [RULE3] [RULE5]
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{pulses_per_turn_setting: abz_pkg::PPT_RESET, shape: abz_pkg::SHAPE_RESET, cnt: '0, div: '0,
                      qa: 1'b0, qb: 1'b0, qz: 1'b0, rdata: '0}; // [RULE14]
        end else begin
            st_q <= st_d;
        end
    end

    assign quad_a = st_q.qa;
    assign quad_b = st_q.qb;
    assign quad_index = st_q.qz;
    assign rdata = st_q.rdata;

    // Receiver recovers angle from duty ratio, not absolute period
    abz_pwm_gen #(
        .ANGLE_W(abz_pkg::ANGLE_W),
        .PAD(abz_pkg::PWM_PAD)
    ) u_pwm (
        .core_clk(core_clk),
        .rst(rst),
        .angle(angle_in),
        .pwm_out(pwm_out)
    ); // [RULE10] [RULE11] [RULE12]

    // Checking helper: set once any pulse-count write has happened
    logic seen_wr_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_wr_q <= 1'b0;
        end else if (wr_en && (addr == abz_pkg::REG_PPT_LO || addr == abz_pkg::REG_PPT_HI)) begin
            seen_wr_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_wr_lo;
        wr_en && addr == abz_pkg::REG_PPT_LO;
    endsequence

    sequence s_wr_hi;
        wr_en && addr == abz_pkg::REG_PPT_HI;
    endsequence

    sequence s_step;
        $past(tick) && !$past(resync) && $changed(st_q.cnt);
    endsequence

    property p_ppt_lo;
        s_wr_lo |=> st_q.pulses_per_turn_setting[1:0] == $past(wdata[abz_pkg::PPT_LO_MSB:abz_pkg::PPT_LO_LSB]);
    endproperty
    a_ppt_lo: assert property (p_ppt_lo) else $error("low pulse bits not stored"); // [RULE2]

    property p_ppt_hi;
        s_wr_hi |=> st_q.pulses_per_turn_setting[9:2] == $past(wdata[abz_pkg::PPT_HI_MSB:abz_pkg::PPT_HI_LSB]);
    endproperty
    a_ppt_hi: assert property (p_ppt_hi) else $error("high pulse bits not stored"); // [RULE2]

    property p_shape;
        s_wr_hi |=> st_q.shape == $past(wdata[abz_pkg::SHAPE_MSB:abz_pkg::SHAPE_LSB]);
    endproperty
    a_shape: assert property (p_shape) else $error("index shape not stored"); // [RULE4]

    property p_ppt_default;
        !seen_wr_q |-> st_q.pulses_per_turn_setting == abz_pkg::PPT_RESET;
    endproperty
    a_ppt_default: assert property (p_ppt_default) else $error("pulse setting left its reset value"); // [RULE14]

    property p_one_channel;
        $changed({st_q.qa, st_q.qb}) |-> !($changed(st_q.qa) && $changed(st_q.qb));
    endproperty
    a_one_channel: assert property (p_one_channel) else $error("A and B changed together"); // [RULE15]

    property p_hysteresis;
        s_step |-> $past(step_up) || $past(step_dn);
    endproperty
    a_hysteresis: assert property (p_hysteresis) else $error("edge moved inside hysteresis band"); // [RULE7]

    property p_edge_tick;
        $changed({st_q.qa, st_q.qb}) && !$past(resync) |-> $past(tick);
    endproperty
    a_edge_tick: assert property (p_edge_tick) else $error("edge outside update slot"); // [RULE8]

    property p_index_start;
        // Turning backwards enters the window from its far end
        $rose(st_q.qz) |-> st_q.cnt == z_start || st_q.cnt == z_start + z_len - 1'b1;
    endproperty
    a_index_start: assert property (p_index_start) else $error("index rose away from zero cell"); // [RULE3]

    property p_index_default;
        st_q.shape == abz_pkg::SHAPE_RESET && $rose(st_q.qz) && $past(st_q.cnt) == EW'(edges - 1'b1)
            |-> $fell(st_q.qb);
    endproperty
    a_index_default: assert property (p_index_default) else $error("index not aligned to B fall"); // [RULE5]

    property p_index_len;
        st_q.shape == abz_pkg::SHAPE_RESET && st_q.qz |-> st_q.cnt < 12'h002;
    endproperty
    a_index_len: assert property (p_index_len) else $error("default index wider than half pulse"); // [RULE6]

    property p_read_pos;
        rd_en && addr == abz_pkg::REG_EDGE_POS |=> rdata == 16'($past(st_q.cnt)) ##1 rdata == '0 || $past(rd_en);
    endproperty
    a_read_pos: assert property (p_read_pos) else $error("edge position readback wrong");

endmodule // abz_encoder_top

// [verification/abz_capture_model.sv]
`timescale 1ns/1ps
module abz_capture_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Lines from the encoder
    input wire logic quad_a,
    input wire logic quad_b,
    input wire logic quad_index,
    input wire logic pwm_out
);
    logic [1:0] c_q;
    logic z_q, p_q;
    logic [15:0] pos, gray_errs, z_rises, z_bad, z_len, z_edges;
    logic [15:0] hi_cnt, lo_cnt, hi_len, lo_len, pwm_rises;
    wire logic [1:0] c_now = {quad_b, quad_a ^ quad_b};
    wire logic [1:0] c_step = c_now - c_q;
    wire logic moved = (c_step != 2'h0);
    // Sampling every clock resolves edges that are one update apart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {c_q, z_q, p_q} <= '0;
            {pos, gray_errs, z_rises, z_bad, z_len, z_edges} <= '0;
            {hi_cnt, lo_cnt, hi_len, lo_len, pwm_rises} <= '0;
        end else begin
            c_q <= c_now;
            z_q <= quad_index;
            p_q <= pwm_out;
            if (c_step == 2'h1) pos <= pos + 16'h0001;
            if (c_step == 2'h3) pos <= pos - 16'h0001;
            // A skipped state means an edge was lost
            if (c_step == 2'h2) gray_errs <= gray_errs + 16'h0001;
            if (z_q && moved) z_len <= z_len + 16'h0001;
            if (quad_index && !z_q) begin
                z_rises <= z_rises + 16'h0001;
                z_len <= 16'h0000;
                if (!(c_q[1] && !quad_b)) z_bad <= z_bad + 16'h0001;
            end
            if (!quad_index && z_q) z_edges <= z_len + {15'h0000, moved};
            // Both phases are timed because the period itself is not trusted
            if (pwm_out) hi_cnt <= hi_cnt + 16'h0001;
            else lo_cnt <= lo_cnt + 16'h0001;
            if (p_q && !pwm_out) begin
                hi_len <= hi_cnt;
                lo_cnt <= 16'h0001;
            end
            if (!p_q && pwm_out) begin
                lo_len <= lo_cnt;
                hi_cnt <= 16'h0001;
                pwm_rises <= pwm_rises + 16'h0001;
            end
        end
    end
endmodule // abz_capture_model

// [verification/abz_encoder_and_pwm_angle_output_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module abz_encoder_and_pwm_angle_output_tb;
    localparam int PER = (1 << abz_pkg::ANGLE_W) + 2 * abz_pkg::PWM_PAD;
    localparam int PULSES_PER_TURN_SETTING = 119;
    logic core_clk, rst, wr_en, rd_en, quad_a, quad_b, quad_index, pwm_out;
    logic [abz_pkg::ANGLE_W-1:0] angle_in;
    logic [abz_pkg::ADDR_W-1:0] addr;
    logic [abz_pkg::DATA_W-1:0] wdata, rdata;
    logic [15:0] p0, zr, zb;
    int num_errors = 0;
    int checked = 0;

    abz_encoder_top i_dut (.core_clk(core_clk), .rst(rst), .angle_in(angle_in), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .quad_a(quad_a), .quad_b(quad_b),
        .quad_index(quad_index), .pwm_out(pwm_out));
    abz_capture_model i_cap (.core_clk(core_clk), .rst(rst), .quad_a(quad_a), .quad_b(quad_b),
        .quad_index(quad_index), .pwm_out(pwm_out));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    task automatic final_report;
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(negedge core_clk);
        `CHK(rdata, exp)
        @(posedge core_clk);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic snap;
        p0 = i_cap.pos;
        zr = i_cap.z_rises;
        zb = i_cap.z_bad;
    endtask

    task automatic wait_rises(input logic [15:0] n);
        for (int i = 0; i < 3 * PER && i_cap.pwm_rises < n; i++) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic t_regs;
        rdchk(abz_pkg::REG_PPT_LO, 16'h00C0);
        rdchk(abz_pkg::REG_PPT_HI, 16'h00FF);
        wr(abz_pkg::REG_PPT_LO, 16'h00C0);
        wr(abz_pkg::REG_PPT_HI, 16'h001D);
        wr(8'h33, 16'hFFFF);
        rdchk(abz_pkg::REG_PPT_LO, 16'h00C0);
        rdchk(abz_pkg::REG_PPT_HI, 16'h001D);
        rdchk(8'h33, 16'h0000);
    endtask

    // First period after reset carries the minimum duty
    task automatic t_pwm_min;
        wait_rises(16'h0002);
        `CHK(i_cap.hi_len, 16'(abz_pkg::PWM_PAD))
        `CHK(i_cap.lo_len, 16'(PER - abz_pkg::PWM_PAD))
    endtask

    task automatic t_sweep_fwd;
        snap();
        // Run past the wrap into the middle of cell zero, clear of the hysteresis band
        for (int a = 1; a <= 16384 + 20; a++) begin
            angle_in <= 14'(a);
            @(posedge core_clk);
        end
        settle(10);
        `CHK(16'(i_cap.pos - p0), 16'(4 * (PULSES_PER_TURN_SETTING + 1)))
        `CHK(16'(i_cap.z_rises - zr), 16'h0001)
        `CHK(16'(i_cap.z_bad - zb), 16'h0000)
        `CHK(i_cap.z_edges, 16'h0002)
        `CHK(i_cap.gray_errs, 16'h0000)
        rdchk(abz_pkg::REG_EDGE_POS, 16'h0000);
    endtask

    task automatic t_sweep_rev;
        snap();
        for (int a = 16382; a >= 0; a -= 2) begin
            angle_in <= 14'(a);
            @(posedge core_clk);
        end
        settle(10);
        `CHK(16'(p0 - i_cap.pos), 16'(4 * (PULSES_PER_TURN_SETTING + 1)))
        `CHK(16'(i_cap.z_rises - zr), 16'h0001)
        `CHK(16'(i_cap.z_bad - zb), 16'h0000)
        `CHK(i_cap.gray_errs, 16'h0000)
    endtask

    task automatic t_jump_hys;
        wr(abz_pkg::REG_PPT_LO, 16'h0000);
        wr(abz_pkg::REG_PPT_HI, 16'h0000);
        settle(4);
        snap();
        angle_in <= 14'h2100;
        settle(3);
        `CHK(16'(i_cap.pos - p0), 16'h0002)
        `CHK({quad_a, quad_b}, 2'b11)
        // Dither one LSB either side of the cell edge
        for (int i = 0; i < 64; i++) begin
            angle_in <= i[0] ? 14'h1FFF : 14'h2001;
            @(posedge core_clk);
        end
        settle(4);
        `CHK(16'(i_cap.pos - p0), 16'h0002)
        angle_in <= 14'h1FC0;
        settle(4);
        `CHK(16'(i_cap.pos - p0), 16'h0001)
    endtask

    // Shape 0101 moves the index to cell one alone
    task automatic t_shape;
        wr(abz_pkg::REG_PPT_HI, 16'h0500);
        settle(3);
        `CHK(quad_index, 1'b1)
        rdchk(abz_pkg::REG_PPT_HI, 16'h0500);
        angle_in <= 14'h0800;
        settle(4);
        `CHK(quad_index, 1'b0)
        wr(abz_pkg::REG_PPT_HI, 16'h0000);
        settle(3);
        `CHK(quad_index, 1'b1)
    endtask

    task automatic t_pwm_max;
        angle_in <= 14'h3FFF;
        rdchk(abz_pkg::REG_ANGLE, 16'h3FFF);
        wait_rises(i_cap.pwm_rises + 16'h0002);
        `CHK(i_cap.hi_len, 16'(16383 + abz_pkg::PWM_PAD))
        `CHK(i_cap.lo_len, 16'(PER - 16383 - abz_pkg::PWM_PAD))
    endtask

    initial begin
        rst = 1'b1;
        angle_in = '0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_pwm_min();
        t_sweep_fwd();
        t_sweep_rev();
        t_jump_hys();
        t_shape();
        t_pwm_max();
        final_report();
    end

    // The longest path is about sixty-six thousand cycles
    initial begin
        repeat (90000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
endmodule // abz_encoder_and_pwm_angle_output_tb
